/* src/blf_regs.sv */
// Module: backlight control and fault-status register bank
`timescale 1ns/10ps
module blf_regs import blf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire blf_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    input wire logic i_enable_pin,
    input wire logic i_pwm_pin,
    input wire blf_sense_t i_sense,
    output logic o_fault_n,
    output logic o_led_pwm,
    output logic o_boost_en,
    output logic o_chip_on
);

    // ===========================================
    // Pin synchronisers
    logic [1:0] en_sync;
    logic [1:0] pwm_sync;
    blf_sense_t sense_meta;
    blf_sense_t sense;

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            en_sync <= 2'h0;
            pwm_sync <= 2'h0;
            sense_meta <= '0;
            sense <= '0;
        end else begin
            en_sync <= {en_sync[0], i_enable_pin};
            pwm_sync <= {pwm_sync[0], i_pwm_pin};
            sense_meta <= i_sense;
            sense <= sense_meta;
        end
    end

    logic enable;
    logic pwm_in;
    assign enable = en_sync[1];
    assign pwm_in = pwm_sync[1];

    function automatic logic [2:0] blf_popcount(input logic [BLF_CHANNELS-1:0] v);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 0; i < BLF_CHANNELS; i++) begin
            n = n + {2'h0, v[i]};
        end
        return n;
    endfunction : blf_popcount

    // ===========================================
    // Registers and fault flags
    logic [7:0] brightness_code;
    logic [7:0] next_brightness_code;
    blf_src_t pwm_source_select;
    blf_src_t next_pwm_source_select;
    logic backlight_on_bit;
    logic next_backlight_on_bit;
    logic [7:0] fault_status;
    logic [7:0] next_fault_status;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic [BLF_OCP_CW-1:0] ocp_count;
    logic [BLF_OCP_CW-1:0] next_ocp_count;
    logic tsd_hold;
    logic next_tsd_hold;
    logic uv_hold;
    logic next_uv_hold;

    logic [BLF_CHANNELS-1:0] chan_fault;
    logic [2:0] nfault;
    logic [7:0] fault_set;
    logic clear_flags;
    logic ocp_event;

    always_comb begin
        next_brightness_code = brightness_code;
        next_pwm_source_select = pwm_source_select;
        next_backlight_on_bit = backlight_on_bit;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        next_ocp_count = ocp_count;
        chan_fault = sense.led_open | sense.led_short;
        nfault = blf_popcount(chan_fault);
        ocp_event = 1'b0;

        // Count only while boost_low is sensed and the overcurrent flag is clear; overcurrent stops the boost and the count
        if (sense.boost_low && !fault_status[BLF_BIT_OCP]) begin
            if (ocp_count >= BLF_OCP_CW'(BLF_OCP_CYCLES)) begin
                ocp_event = 1'b1;
                next_ocp_count = '0;
            end else begin
                next_ocp_count = ocp_count + 1'b1;
            end
        end else begin
            next_ocp_count = '0;
        end

        fault_set = 8'h00;
        fault_set[BLF_BIT_OPEN] = |sense.led_open;
        fault_set[BLF_BIT_SHORT] = |sense.led_short;
        fault_set[BLF_BIT_MULTI] = (nfault >= 3'h2);
        fault_set[BLF_BIT_SINGLE] = (nfault == 3'h1);
        fault_set[BLF_BIT_ANY] = |chan_fault;
        fault_set[BLF_BIT_OCP] = ocp_event;
        fault_set[BLF_BIT_TSD] = sense.over_temp;
        fault_set[BLF_BIT_INPUT_UNDERVOLTAGE_FLAG] = sense.under_volt;

        // Read clear; a new event in the same cycle survives
        clear_flags = !enable || (i_req.rd && i_req.addr == BLF_ADDR_FAULT);
        next_fault_status = (clear_flags ? 8'h00 : fault_status) | fault_set;

        // Protection holds run on sensors, independent of the flag clear
        next_tsd_hold = sense.over_temp ? 1'b1 : (sense.temp_cool ? 1'b0 : tsd_hold);
        next_uv_hold = sense.under_volt ? 1'b1 : (sense.vin_ok ? 1'b0 : uv_hold);

        if (i_req.wr) begin
            if (i_req.addr == BLF_ADDR_BRIGHTNESS) begin
                next_brightness_code = i_req.wdata;
            end else if (i_req.addr == BLF_ADDR_DEVCTL) begin
                next_backlight_on_bit = i_req.wdata[BLF_BIT_ON];
                next_pwm_source_select = blf_src_t'(i_req.wdata[BLF_BIT_SRC_LO +: 2]);
            end
        end

        if (i_req.rd) begin
            next_rvalid = 1'b1;
            if (i_req.addr == BLF_ADDR_BRIGHTNESS) begin
                next_rdata = brightness_code;
            end else if (i_req.addr == BLF_ADDR_DEVCTL) begin
                next_rdata = {5'h00, pwm_source_select, backlight_on_bit};
            end else if (i_req.addr == BLF_ADDR_FAULT) begin
                next_rdata = fault_status;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            brightness_code <= BLF_RESET_BRIGHTNESS;
            pwm_source_select <= blf_src_t'(BLF_RESET_DEVCTL[BLF_BIT_SRC_LO +: 2]);
            backlight_on_bit <= BLF_RESET_DEVCTL[BLF_BIT_ON];
            fault_status <= BLF_RESET_FAULT;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            ocp_count <= '0;
            tsd_hold <= 1'b0;
            uv_hold <= 1'b0;
        end else begin
            brightness_code <= next_brightness_code;
            pwm_source_select <= next_pwm_source_select;
            backlight_on_bit <= next_backlight_on_bit;
            fault_status <= next_fault_status;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            ocp_count <= next_ocp_count;
            tsd_hold <= next_tsd_hold;
            uv_hold <= next_uv_hold;
        end
    end

    // ===========================================
    // Output path
    logic reg_pwm;

    blf_pwm u_pwm (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_duty(brightness_code),
        .o_pwm(reg_pwm)
    );

    logic led_pwm;
    logic next_led_pwm;
    logic boost_en;
    logic next_boost_en;
    logic chip_on;
    logic next_chip_on;
    logic fault_n;
    logic next_fault_n;
    logic protect;

    always_comb begin
        protect = tsd_hold || uv_hold;
        if (pwm_source_select == BLF_SRC_REG) begin
            next_chip_on = backlight_on_bit;
            next_led_pwm = backlight_on_bit && reg_pwm;
        end else begin
            // Pin duty modes: the pin decides on or off, gated by enable; the on bit is ignored
            next_chip_on = pwm_in;
            next_led_pwm = pwm_in;
        end
        next_chip_on = next_chip_on && enable;
        next_led_pwm = next_led_pwm && next_chip_on && !protect;
        // Boost resumes as soon as the overcurrent flag is gone
        next_boost_en = next_chip_on && !protect && !fault_status[BLF_BIT_OCP];
        next_fault_n = ~|fault_status;
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            led_pwm <= 1'b0;
            boost_en <= 1'b0;
            chip_on <= 1'b0;
            fault_n <= 1'b1;
        end else begin
            led_pwm <= next_led_pwm;
            boost_en <= next_boost_en;
            chip_on <= next_chip_on;
            fault_n <= next_fault_n;
        end
    end

    assign o_rdata = rdata;
    assign o_rvalid = rvalid;
    assign o_led_pwm = led_pwm;
    assign o_boost_en = boost_en;
    assign o_chip_on = chip_on;
    assign o_fault_n = fault_n;

endmodule : blf_regs

/* src/blf_pkg.sv */
// Package: register map, field layout, timing and carrier types of the backlight control block
package blf_pkg;

    // ===========================================
    // Register map
    localparam logic [7:0] BLF_ADDR_BRIGHTNESS = 8'h00;
    localparam logic [7:0] BLF_ADDR_DEVCTL = 8'h01;
    localparam logic [7:0] BLF_ADDR_FAULT = 8'h02;
    localparam logic [7:0] BLF_RESET_BRIGHTNESS = 8'h00;
    localparam logic [7:0] BLF_RESET_DEVCTL = 8'h00;
    localparam logic [7:0] BLF_RESET_FAULT = 8'h00;

    // ===========================================
    // Field positions
    localparam int BLF_BIT_ON = 0;
    localparam int BLF_BIT_SRC_LO = 1;
    localparam int BLF_BIT_OPEN = 7;
    localparam int BLF_BIT_SHORT = 6;
    localparam int BLF_BIT_MULTI = 5;
    localparam int BLF_BIT_SINGLE = 4;
    localparam int BLF_BIT_ANY = 3;
    localparam int BLF_BIT_OCP = 2;
    localparam int BLF_BIT_TSD = 1;
    localparam int BLF_BIT_INPUT_UNDERVOLTAGE_FLAG = 0;
    localparam int BLF_CHANNELS = 6;

    // ===========================================
    // Source selection codes
    typedef enum logic [1:0] {
        BLF_SRC_PIN_A = 2'h0,
        BLF_SRC_PIN_B = 2'h1,
        BLF_SRC_REG = 2'h2,
        BLF_SRC_DIRECT = 2'h3
    } blf_src_t;

    // ===========================================
    // Timing
    localparam int BLF_CLK_HZ = 50_000_000;
    localparam int BLF_OCP_MS = 50;
    localparam int BLF_OCP_CYCLES = (BLF_CLK_HZ / 1000) * BLF_OCP_MS;
    localparam int BLF_OCP_CW = 22;

    // ===========================================
    // Register access request from the serial port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } blf_req_t;

    // Analog fault indications, synchronised by two flops inside blf_regs
    typedef struct packed {
        logic [BLF_CHANNELS-1:0] led_open;
        logic [BLF_CHANNELS-1:0] led_short;
        logic boost_low;
        logic over_temp;
        logic temp_cool;
        logic under_volt;
        logic vin_ok;
    } blf_sense_t;

endpackage : blf_pkg

/* src/blf_pwm.sv */
// Module: 8-bit linear PWM generator for register-controlled brightness
`timescale 1ns/10ps
module blf_pwm import blf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [7:0] i_duty,
    output logic o_pwm
);

    logic [7:0] count;
    logic [7:0] next_count;
    logic pwm;
    logic next_pwm;

    always_comb begin
        next_count = count + 8'h01;
        // Full scale code gives steady on
        next_pwm = (i_duty == 8'hff) || (count < i_duty);
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            count <= 8'h00;
            pwm <= 1'b0;
        end else begin
            count <= next_count;
            pwm <= next_pwm;
        end
    end

    assign o_pwm = pwm;

endmodule : blf_pwm

/* testbench/blf_host.sv */
// Host-side partner issuing register requests on the system clock
`timescale 1ns/10ps
module blf_host import blf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output blf_req_t o_req
);
    initial o_req = '0;

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk_sys);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_clk_sys);
        o_req <= '0;
    endtask : write_reg

    // Fault flags are acknowledged by reading them or by holding the enable pin low
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        bit got;
        got = 1'b0;
        data = 8'hxx;
        @(posedge i_clk_sys);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge i_clk_sys);
        o_req <= '0;
        for (int k = 0; k < 3 && !got; k++) begin
            @(negedge i_clk_sys);
            if (i_rvalid === 1'b1) begin
                data = i_rdata;
                got = 1'b1;
            end
        end
    endtask : read_reg
endmodule : blf_host

/* testbench/blf_regs_sva.sv */
// Port-level assertions for the backlight register bank
`timescale 1ns/10ps
module blf_regs_sva import blf_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire blf_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_enable_pin,
    input wire logic i_pwm_pin,
    input wire blf_sense_t i_sense,
    input wire logic o_fault_n,
    input wire logic o_led_pwm,
    input wire logic o_boost_en,
    input wire logic o_chip_on
);
    logic [7:0] ctl;
    logic [7:0] br;
    logic [7:0] next_ctl;
    logic [7:0] next_br;

    // ===========================================
    // Shadow of written registers
    always_comb begin
        next_ctl = ctl;
        next_br = br;
        if (i_req.wr && i_req.addr == BLF_ADDR_DEVCTL) begin
            next_ctl = {5'h00, i_req.wdata[2:0]};
        end
        if (i_req.wr && i_req.addr == BLF_ADDR_BRIGHTNESS) begin
            next_br = i_req.wdata;
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            ctl <= 8'h00;
            br <= 8'h00;
        end else begin
            ctl <= next_ctl;
            br <= next_br;
        end
    end

    // ===========================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    read_answer_a: assert property (i_req.rd |=> o_rvalid) else $error("read not answered");
    read_quiet_a: assert property (!i_req.rd |=> !o_rvalid) else $error("stray read valid");
    bright_back_a: assert property (i_req.rd && i_req.addr == BLF_ADDR_BRIGHTNESS |=> o_rdata == br)
        else $error("brightness readback wrong");
    ctl_back_a: assert property (i_req.rd && i_req.addr == BLF_ADDR_DEVCTL |=> o_rdata == ctl)
        else $error("control readback wrong");
    unmapped_zero_a: assert property (i_req.rd && i_req.addr > BLF_ADDR_FAULT |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    led_pin_a: assert property ((|{i_sense.led_open, i_sense.led_short} && i_enable_pin) [*6] |-> !o_fault_n)
        else $error("fault pin not low");
    thermal_off_a: assert property (i_sense.over_temp [*6] |-> !o_boost_en && !o_led_pwm)
        else $error("outputs on while hot");
    undervolt_off_a: assert property (i_sense.under_volt [*6] |-> !o_boost_en && !o_led_pwm)
        else $error("outputs on in undervoltage");
    enable_low_a: assert property (!i_enable_pin [*6] |-> o_fault_n && !o_chip_on)
        else $error("enable low not honoured");
    reg_off_a: assert property (ctl == 8'h04 [*3] |-> !o_chip_on && !o_led_pwm)
        else $error("chip on with on bit clear");
endmodule : blf_regs_sva

bind blf_regs blf_regs_sva u_sva (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_enable_pin(i_enable_pin), .i_pwm_pin(i_pwm_pin), .i_sense(i_sense),
    .o_fault_n(o_fault_n), .o_led_pwm(o_led_pwm), .o_boost_en(o_boost_en), .o_chip_on(o_chip_on));

/* testbench/blf_regs_tb.sv */
// Self-checking bench for the backlight register bank
`timescale 1ns/10ps
module blf_regs_tb import blf_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en_pin = 1'b1;
    logic pwm_pin = 1'b0;
    blf_sense_t sense;
    blf_sense_t idle;
    blf_sense_t s;
    blf_req_t req;
    logic [7:0] rdata;
    logic rvalid, fault_n, led_pwm, boost_en, chip_on;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_high = 0;
    logic [7:0] exp_tab [5] = '{8'h98, 8'h68, 8'he8, 8'h02, 8'h01};

    initial forever #10 clk = ~clk;

    blf_host u_host (.i_clk_sys(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    blf_regs uut (.i_clk_sys(clk), .i_reset(rst), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
        .i_enable_pin(en_pin), .i_pwm_pin(pwm_pin), .i_sense(sense), .o_fault_n(fault_n),
        .o_led_pwm(led_pwm), .o_boost_en(boost_en), .o_chip_on(chip_on));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        chk(name, exp, d);
    endtask : rd_chk

    // Covers the two sync flops and the output flop with margin
    task automatic settle(input blf_sense_t v);
        @(posedge clk);
        sense <= v;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic end_sim();
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        idle = '0;
        idle.temp_cool = 1'b1;
        idle.vin_ok = 1'b1;
        sense = idle;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rd_chk("bright_reset", BLF_ADDR_BRIGHTNESS, BLF_RESET_BRIGHTNESS);
        rd_chk("devctl_reset", BLF_ADDR_DEVCTL, BLF_RESET_DEVCTL);
        rd_chk("fault_reset", BLF_ADDR_FAULT, BLF_RESET_FAULT);
        u_host.write_reg(BLF_ADDR_BRIGHTNESS, 8'ha5);
        u_host.write_reg(BLF_ADDR_DEVCTL, 8'hff);
        u_host.write_reg(BLF_ADDR_FAULT, 8'hff);
        rd_chk("bright_rw", BLF_ADDR_BRIGHTNESS, 8'ha5);
        rd_chk("devctl_rw", BLF_ADDR_DEVCTL, 8'h07);
        rd_chk("fault_ro", BLF_ADDR_FAULT, 8'h00);
        rd_chk("unmapped", 8'h7f, 8'h00);
        u_host.write_reg(BLF_ADDR_BRIGHTNESS, 8'hff);
        u_host.write_reg(BLF_ADDR_DEVCTL, 8'h05);
        settle(idle);
        chk("chip_on_reg", 8'h01, {7'h00, chip_on});
        chk("pwm_full", 8'h01, {7'h00, led_pwm});
        u_host.write_reg(BLF_ADDR_BRIGHTNESS, 8'h00);
        settle(idle);
        chk("pwm_zero", 8'h00, {7'h00, led_pwm});
        // One full PWM period: high count must equal the code
        u_host.write_reg(BLF_ADDR_BRIGHTNESS, 8'h40);
        settle(idle);
        repeat (256) begin
            @(negedge clk);
            if (led_pwm === 1'b1) n_high++;
        end
        chk("pwm_quarter", 8'h40, n_high[7:0]);
        u_host.write_reg(BLF_ADDR_DEVCTL, 8'h04);
        settle(idle);
        chk("chip_off_reg", 8'h00, {7'h00, chip_on});
        // ===========================================
        // Pin source modes: on bit must not matter
        for (int c = 0; c < 4; c++) begin
            for (int b = 0; b < 4; b++) begin
                if (c != 2) begin
                    u_host.write_reg(BLF_ADDR_DEVCTL, {5'h00, c[1:0], b[0]});
                    pwm_pin <= b[1];
                    settle(idle);
                    chk("chip_on_pin", {7'h00, b[1]}, {7'h00, chip_on});
                end
            end
        end
        // ===========================================
        // Fault flags, pin and clear on read
        for (int k = 0; k < 5; k++) begin
            s = idle;
            case (k)
                0: s.led_open = 6'h01;
                1: s.led_short = 6'h06;
                2: begin s.led_open = 6'h01; s.led_short = 6'h08; end
                3: begin s.over_temp = 1'b1; s.temp_cool = 1'b0; end
                default: begin s.under_volt = 1'b1; s.vin_ok = 1'b0; end
            endcase
            settle(s);
            chk("fault_pin_set", 8'h00, {7'h00, fault_n});
            if (k > 2) chk("boost_off", 8'h00, {7'h00, boost_en});
            // Trip gone but not yet recovered: boost must stay off
            s.over_temp = 1'b0;
            s.under_volt = 1'b0;
            settle(s);
            if (k > 2) chk("boost_held", 8'h00, {7'h00, boost_en});
            settle(idle);
            rd_chk("fault_flags", BLF_ADDR_FAULT, exp_tab[k]);
            rd_chk("fault_cleared", BLF_ADDR_FAULT, 8'h00);
            chk("fault_pin_clr", 8'h01, {7'h00, fault_n});
            chk("boost_on", 8'h01, {7'h00, boost_en});
        end
        s = idle;
        s.led_open = 6'h20;
        settle(s);
        settle(idle);
        @(posedge clk);
        en_pin <= 1'b0;
        settle(idle);
        chk("chip_off_en", 8'h00, {7'h00, chip_on});
        @(posedge clk);
        en_pin <= 1'b1;
        settle(idle);
        rd_chk("fault_en_clr", BLF_ADDR_FAULT, 8'h00);
        end_sim();
    end
endmodule : blf_regs_tb
